// *** src/bhr_io_window.sv ***
// banked host i/o register window: sixteen byte locations, bank selector on top
// assumes io_rd and io_wr are one-cycle strobes, never both in one cycle, and
// io_addr carries address bits 3:2 with lanes picked by byte_lane_enables_n
`timescale 1ns/1ps
`default_nettype none

module bhr_io_window (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // host bus
    input  wire logic [1:0]  io_addr,
    input  wire logic [3:0]  byte_lane_enables_n,
    input  wire logic        io_rd,
    input  wire logic        io_wr,
    input  wire logic [31:0] io_data_in,
    output logic      [31:0] io_data_out,
    output logic             io_data_oe,
    // device status inputs
    input  wire logic [15:0] bus_error_set,
    input  wire logic [15:0] memory_selftest_info,
    input  wire logic        prom_data_in,
    // configuration outputs
    output logic      [15:0] bank_selector,
    output logic      [15:0] io_base_address,
    output logic      [47:0] station_address,
    output logic      [15:0] rx_flow_watermark,
    output logic      [15:0] host_burst_length,
    output logic      [15:0] internal_bus_control,
    output logic      [15:0] host_bus_configuration,
    output logic      [3:0]  serial_prom_control,
    output logic             global_soft_reset,
    // packet store core port
    input  wire logic        core_pkt_we,
    input  wire logic [3:0]  core_pkt_addr,
    input  wire logic [31:0] core_pkt_wdata,
    output logic      [31:0] core_pkt_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic [3:0]  off_half [2];
    logic [1:0]  lane_half [2];
    logic [15:0] data_half [2];
    logic [3:0]  lanes;
    logic [15:0] bank_q;
    logic        pkt_hit;
    logic        pkt_ptr_hit;

    assign lanes        = ~byte_lane_enables_n;
    assign off_half[0]  = {io_addr, 2'b00};
    assign off_half[1]  = {io_addr, 2'b10};
    assign lane_half[0] = lanes[1:0];
    assign lane_half[1] = lanes[3:2];
    assign data_half[0] = io_data_in[15:0];
    assign data_half[1] = io_data_in[31:16];

    assign pkt_hit     = (bank_q == bhr_pkg::PKT_BANK) &&
                         (io_addr == bhr_pkg::PKT_DATA_DW) && (lanes != 4'h0);
    assign pkt_ptr_hit = (bank_q == bhr_pkg::PKT_BANK) &&
                         (off_half[0] == bhr_pkg::PKT_PTR_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // read-write registers

    logic [1:0]  rw_we [bhr_pkg::N_RW];
    logic [15:0] rw_wd [bhr_pkg::N_RW];
    logic [15:0] rw_q  [bhr_pkg::N_RW];
    logic [1:0]  bsel_we;
    logic [1:0]  err_clr;

    always_comb
    begin
        bsel_we = 2'b00;
        err_clr = 2'b00;
        for (int i = 0; i < bhr_pkg::N_RW; i++)
        begin
            rw_we[i] = 2'b00;
            rw_wd[i] = 16'h0000;
        end
        for (int h = 0; h < 2; h++)
        begin
            if (io_wr && off_half[h] == bhr_pkg::BSEL_OFF)
            begin
                bsel_we = lane_half[h];
            end
            if (io_wr && bank_q == bhr_pkg::ERR_BANK && off_half[h] == bhr_pkg::ERR_OFF)
            begin
                err_clr = lane_half[h];
            end
            for (int i = 0; i < bhr_pkg::N_RW; i++)
            begin
                if (io_wr && bank_q == bhr_pkg::RW_BANK[i] &&
                    off_half[h] == bhr_pkg::RW_OFF[i])
                begin
                    rw_we[i] = lane_half[h];
                    rw_wd[i] = data_half[h];
                end
            end
        end
    end

    generate
        for (genvar g = 0; g < bhr_pkg::N_RW; g++)
        begin : g_rw
            bhr_lane_reg #(
                .RESET (bhr_pkg::RW_RESET[g])
            ) u_reg (
                .clock (clock),
                .rst_n (rst_n),
                .we    (rw_we[g]),
                .wdata (rw_wd[g]),
                .q     (rw_q[g])
            );
        end
    endgenerate

    bhr_lane_reg #(
        .RESET (bhr_pkg::BSEL_RESET)
    ) u_bank_sel (
        .clock (clock),
        .rst_n (rst_n),
        .we    (bsel_we),
        .wdata (io_data_in[31:16]),
        .q     (bank_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus error status: hardware sets, host writes one to clear, set wins

    logic [15:0] err_q;
    logic [15:0] err_clr_bits;

    assign err_clr_bits = ({{8{err_clr[1]}}, {8{err_clr[0]}}} &
                           (off_half[1] == bhr_pkg::ERR_OFF ? io_data_in[31:16]
                                                            : io_data_in[15:0]));

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            err_q <= 16'h0000;
        end
        else
        begin
            err_q <= (err_q & ~err_clr_bits) | bus_error_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // packet data path: pointer advances after every data access with at least one byte lane enabled

    logic [3:0]  pkt_ptr_q;
    logic [31:0] pkt_rdata;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pkt_ptr_q <= 4'h0;
        end
        else if ((io_rd || io_wr) && pkt_hit)
        begin
            pkt_ptr_q <= pkt_ptr_q + 4'h1;
        end
        else if (io_wr && pkt_ptr_hit && lanes[0])
        begin
            pkt_ptr_q <= io_data_in[3:0];
        end
    end

    bhr_pkt_mem u_pkt (
        .clock   (clock),
        .a_en    ((io_rd || io_wr) && pkt_hit),
        .a_be    (lanes),
        .a_addr  (pkt_ptr_q),
        .a_wdata (io_data_in),
        .a_we    (io_wr),
        .a_rdata (pkt_rdata),
        .b_we    (core_pkt_we),
        .b_addr  (core_pkt_addr),
        .b_wdata (core_pkt_wdata),
        .b_rdata (core_pkt_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read mux: unmapped and reserved half-words return zero

    logic [15:0] rd_half [2];

    always_comb
    begin
        for (int h = 0; h < 2; h++)
        begin
            rd_half[h] = 16'h0000;
            if (off_half[h] == bhr_pkg::BSEL_OFF)
            begin
                rd_half[h] = bank_q;
            end
            else if (bank_q == bhr_pkg::ERR_BANK && off_half[h] == bhr_pkg::ERR_OFF)
            begin
                rd_half[h] = err_q;
            end
            else if (bank_q == bhr_pkg::BIST_BANK && off_half[h] == bhr_pkg::BIST_OFF)
            begin
                rd_half[h] = memory_selftest_info;
            end
            else if (bank_q == bhr_pkg::PKT_BANK && off_half[h] == bhr_pkg::PKT_PTR_OFF)
            begin
                rd_half[h] = {12'h000, pkt_ptr_q};
            end
            for (int i = 0; i < bhr_pkg::N_RW; i++)
            begin
                if (bank_q == bhr_pkg::RW_BANK[i] && off_half[h] == bhr_pkg::RW_OFF[i])
                begin
                    rd_half[h] = rw_q[i];
                    if (i == bhr_pkg::R_PROM)
                    begin
                        rd_half[h] = rw_q[i] & bhr_pkg::PROM_RW_MASK;
                        rd_half[h][bhr_pkg::PROM_IN_BIT] = prom_data_in;
                    end
                end
            end
        end
    end

    logic [31:0] rd_q;
    logic [3:0]  rd_lanes_q;
    logic        rd_pkt_q;
    logic        rd_act_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rd_q       <= 32'h0000_0000;
            rd_lanes_q <= 4'h0;
            rd_pkt_q   <= 1'b0;
            rd_act_q   <= 1'b0;
        end
        else
        begin
            rd_act_q <= io_rd;
            if (io_rd)
            begin
                rd_q       <= {rd_half[1], rd_half[0]};
                rd_lanes_q <= lanes;
                rd_pkt_q   <= pkt_hit;
            end
        end
    end

    logic [31:0] lane_mask;

    assign lane_mask   = {{8{rd_lanes_q[3]}}, {8{rd_lanes_q[2]}},
                          {8{rd_lanes_q[1]}}, {8{rd_lanes_q[0]}}};
    assign io_data_out = (rd_pkt_q ? pkt_rdata : rd_q) & lane_mask;
    assign io_data_oe  = rd_act_q;

    ////////////////////////////////////////////////////////////////////////////
    // configuration outputs

    assign bank_selector          = bank_q;
    assign io_base_address        = rw_q[bhr_pkg::R_BASE];
    assign rx_flow_watermark      = rw_q[bhr_pkg::R_WMARK];
    assign host_burst_length      = rw_q[bhr_pkg::R_BURST];
    assign station_address        = {rw_q[bhr_pkg::R_MAC_HI], rw_q[bhr_pkg::R_MAC_MID],
                                     rw_q[bhr_pkg::R_MAC_LO]};
    assign internal_bus_control   = rw_q[bhr_pkg::R_IBC];
    assign host_bus_configuration = rw_q[bhr_pkg::R_BCFG];
    assign serial_prom_control    = rw_q[bhr_pkg::R_PROM][3:0];
    assign global_soft_reset      = rw_q[bhr_pkg::R_GRST][bhr_pkg::GRST_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_bank_write: assert property (
        io_wr && io_addr == 2'h3 && lanes[3:2] == 2'b11
        |=> bank_selector == $past(io_data_in[31:16]))
        else $error("bank selector not written");

    a_bank_shared: assert property (
        io_rd && io_addr == 2'h3 && lanes == 4'hC
        |=> io_data_out == {bank_selector, 16'h0000})
        else $error("bank selector not visible in this bank");

    a_read_answer: assert property (
        io_data_oe == $past(io_rd))
        else $error("read answer not exactly one cycle after its strobe");

    a_lane_zero: assert property (
        io_rd && byte_lane_enables_n[0] |=> io_data_out[7:0] == 8'h00)
        else $error("disabled lane drives data");

    a_word_write: assert property (
        io_wr && bank_q == 16'h0002 && io_addr == 2'h0 && lanes == 4'hF
        |=> station_address[31:0] == $past(io_data_in))
        else $error("word write to station address lost");

    a_byte_write: assert property (
        io_wr && bank_q == 16'h0000 && io_addr == 2'h0 && lanes == 4'h2
        |=> io_base_address == {$past(io_data_in[15:8]), $past(io_base_address[7:0])})
        else $error("byte write touched wrong lane");

    a_pkt_advance: assert property (
        (io_rd || io_wr) && pkt_hit |=> pkt_ptr_q == $past(pkt_ptr_q) + 4'h1)
        else $error("packet pointer did not advance");

    a_rsvd_zero: assert property (
        io_rd && bank_q == 16'h0001 && io_addr != 2'h3 |=> io_data_out == 32'h0000_0000)
        else $error("reserved location read nonzero");

    a_err_set: assert property (
        bus_error_set[0] |=> err_q[0])
        else $error("error event lost");

endmodule : bhr_io_window

`default_nettype wire

// *** src/bhr_lane_reg.sv ***
// one 16-bit register with two byte-lane write enables
// assumes lane enables are already decoded for this register
`timescale 1ns/1ps
`default_nettype none

module bhr_lane_reg #(
    parameter logic [15:0] RESET = 16'h0000
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // write side
    input  wire logic [1:0]  we,
    input  wire logic [15:0] wdata,
    // value
    output logic      [15:0] q
);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            q <= RESET;
        end
        else
        begin
            if (we[0])
            begin
                q[7:0] <= wdata[7:0];
            end
            if (we[1])
            begin
                q[15:8] <= wdata[15:8];
            end
        end
    end

endmodule : bhr_lane_reg

`default_nettype wire

// *** src/bhr_pkg.sv ***
// constants for the banked host i/o register window
// assumes a 16-byte window seen as four aligned 32-bit dwords with byte lanes
package bhr_pkg;

    // rw register table: index, bank, byte offset of the half-word, reset value
    localparam int N_RW      = 10;
    localparam int R_BASE    = 0;
    localparam int R_WMARK   = 1;
    localparam int R_BURST   = 2;
    localparam int R_MAC_LO  = 3;
    localparam int R_MAC_MID = 4;
    localparam int R_MAC_HI  = 5;
    localparam int R_IBC     = 6;
    localparam int R_GRST    = 7;
    localparam int R_BCFG    = 8;
    localparam int R_PROM    = 9;

    localparam logic [15:0] RW_BANK [N_RW] = '{16'h0000, 16'h0000, 16'h0000,
                                               16'h0002, 16'h0002, 16'h0002,
                                               16'h0003, 16'h0003, 16'h0003,
                                               16'h0003};
    localparam logic [3:0]  RW_OFF  [N_RW] = '{4'h0, 4'h4, 4'h8, 4'h0, 4'h2,
                                               4'h4, 4'h0, 4'h6, 4'h8, 4'h2};
    localparam logic [15:0] RW_RESET [N_RW] = '{16'h0000, 16'h0000, 16'h0000,
                                                16'h0000, 16'h0000, 16'h0000,
                                                16'h0000, 16'h0000, 16'h0000,
                                                16'h0000};

    // status and read-only locations
    localparam logic [15:0] ERR_BANK      = 16'h0000;
    localparam logic [3:0]  ERR_OFF       = 4'h6;
    localparam logic [15:0] BIST_BANK     = 16'h0003;
    localparam logic [3:0]  BIST_OFF      = 4'h4;

    // bank selector, present in every bank
    localparam logic [3:0]  BSEL_OFF      = 4'hE;
    localparam logic [15:0] BSEL_RESET    = 16'h0000;

    // serial prom control: low bits writable, one bit reflects the prom data pin
    localparam logic [15:0] PROM_RW_MASK  = 16'h000F;
    localparam int          PROM_IN_BIT   = 4;
    localparam int          GRST_BIT      = 0;

    // packet data path
    localparam logic [15:0] PKT_BANK      = 16'h0011;
    localparam logic [3:0]  PKT_PTR_OFF   = 4'h4;
    localparam logic [1:0]  PKT_DATA_DW   = 2'h2;
    localparam int          PKT_AW        = 4;
    localparam int          PKT_DEPTH     = 16;

endpackage : bhr_pkg

// *** src/bhr_pkt_mem.sv ***
// packet data store, host port with byte lanes and a core port, both registered reads
// assumes the host port wins when both ports write the same word in one cycle
`timescale 1ns/1ps
`default_nettype none

module bhr_pkt_mem (
    // clock
    input  wire logic                      clock,
    // host port
    input  wire logic                      a_en,
    input  wire logic [3:0]                a_be,
    input  wire logic [bhr_pkg::PKT_AW-1:0] a_addr,
    input  wire logic [31:0]               a_wdata,
    input  wire logic                      a_we,
    output logic      [31:0]               a_rdata,
    // core port
    input  wire logic                      b_we,
    input  wire logic [bhr_pkg::PKT_AW-1:0] b_addr,
    input  wire logic [31:0]               b_wdata,
    output logic      [31:0]               b_rdata
);

    logic [31:0] mem [bhr_pkg::PKT_DEPTH];

    always_ff @(posedge clock)
    begin
        if (b_we)
        begin
            mem[b_addr] <= b_wdata;
        end
        for (int i = 0; i < 4; i++)
        begin
            if (a_en && a_we && a_be[i])
            begin
                mem[a_addr][8*i +: 8] <= a_wdata[8*i +: 8];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (a_en)
        begin
            a_rdata <= mem[a_addr];
        end
        b_rdata <= mem[b_addr];
    end

endmodule : bhr_pkt_mem

`default_nettype wire

// *** testbench/bhr_host_model.sv ***
// host cpu model for the banked i/o window: strobes, address and byte lanes
// assumes the bench calls op and idle at falling clock edges only
`timescale 1ns/1ps
`default_nettype none

module bhr_host_model (
    // clock
    input  wire logic        clock,
    // host bus
    output logic      [1:0]  io_addr,
    output logic      [3:0]  byte_lane_enables_n,
    output logic             io_rd,
    output logic             io_wr,
    output logic      [31:0] io_data_in
);
    initial
    begin
        io_addr             = 2'h0;
        byte_lane_enables_n = 4'hF;
        io_rd               = 1'b0;
        io_wr               = 1'b0;
        io_data_in          = 32'h0000_0000;
    end

    // one strobe cycle, left raised so that another op may follow at once
    task automatic op(input logic wr, input logic [1:0] a, input logic [3:0] be_n,
                      input logic [31:0] d);
        io_wr               = wr;
        io_rd               = !wr;
        io_addr             = a;
        byte_lane_enables_n = be_n;
        io_data_in          = wr ? d : ~io_data_in;
        @(negedge clock);
    endtask : op

    // released bus: data keeps changing so a stale value never looks valid
    task automatic idle();
        io_wr               = 1'b0;
        io_rd               = 1'b0;
        byte_lane_enables_n = 4'hF;
        io_data_in          = ~io_data_in;
        @(negedge clock);
    endtask : idle
endmodule : bhr_host_model
`default_nettype wire

// *** testbench/tb_bhr_io_window.sv ***
// self-checking bench for the banked host i/o register window
// assumes the host model drives the bus; a reference map here predicts reads
`timescale 1ns/1ps
`default_nettype none

module tb_bhr_io_window;
    logic        clock, rst_n, io_rd, io_wr, io_data_oe, prom_v, global_soft_reset, core_pkt_we;
    logic [1:0]  io_addr;
    logic [3:0]  byte_lane_enables_n, serial_prom_control, core_pkt_addr;
    logic [31:0] io_data_in, io_data_out, core_pkt_wdata, core_pkt_rdata, seed, r, d;
    logic [15:0] eset, bist_v, bank_selector, io_base_address, rx_flow_watermark;
    logic [15:0] host_burst_length, internal_bus_control, host_bus_configuration;
    logic [47:0] station_address;
    logic [15:0] rw_m [bhr_pkg::N_RW];
    logic [15:0] bsel_m, err_m;
    logic [31:0] pk [16];
    logic [31:0] exp_q [$];
    logic [3:0]  be_tab [7] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hC, 4'h3, 4'h0};
    logic [3:0]  bs_tab [3] = '{4'h3, 4'hB, 4'h0};
    int          n_fail, compares;

    bhr_host_model host_u (
        .clock               (clock),
        .io_addr             (io_addr),
        .byte_lane_enables_n (byte_lane_enables_n),
        .io_rd               (io_rd),
        .io_wr               (io_wr),
        .io_data_in          (io_data_in)
    );

    bhr_io_window dut_u (
        .clock                  (clock),
        .rst_n                  (rst_n),
        .io_addr                (io_addr),
        .byte_lane_enables_n    (byte_lane_enables_n),
        .io_rd                  (io_rd),
        .io_wr                  (io_wr),
        .io_data_in             (io_data_in),
        .io_data_out            (io_data_out),
        .io_data_oe             (io_data_oe),
        .bus_error_set          (eset),
        .memory_selftest_info   (bist_v),
        .prom_data_in           (prom_v),
        .bank_selector          (bank_selector),
        .io_base_address        (io_base_address),
        .station_address        (station_address),
        .rx_flow_watermark      (rx_flow_watermark),
        .host_burst_length      (host_burst_length),
        .internal_bus_control   (internal_bus_control),
        .host_bus_configuration (host_bus_configuration),
        .serial_prom_control    (serial_prom_control),
        .global_soft_reset      (global_soft_reset),
        .core_pkt_we            (core_pkt_we),
        .core_pkt_addr          (core_pkt_addr),
        .core_pkt_wdata         (core_pkt_wdata),
        .core_pkt_rdata         (core_pkt_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always #25 clock = ~clock;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] lmask(input logic [3:0] be_n);
        return {{8{!be_n[3]}}, {8{!be_n[2]}}, {8{!be_n[1]}}, {8{!be_n[0]}}};
    endfunction : lmask

    // expected half-word at a byte offset in the current bank
    function automatic logic [15:0] hw_exp(input logic [3:0] off);
        logic [15:0] v;
        v = 16'h0000;
        if (off == bhr_pkg::BSEL_OFF) v = bsel_m;
        for (int i = 0; i < bhr_pkg::N_RW; i++)
            if (bsel_m == bhr_pkg::RW_BANK[i] && off == bhr_pkg::RW_OFF[i]) v = rw_m[i];
        if (bsel_m == bhr_pkg::ERR_BANK && off == bhr_pkg::ERR_OFF) v = err_m;
        if (bsel_m == bhr_pkg::BIST_BANK && off == bhr_pkg::BIST_OFF) v = bist_v;
        if (bsel_m == bhr_pkg::RW_BANK[bhr_pkg::R_PROM] && off == bhr_pkg::RW_OFF[bhr_pkg::R_PROM])
            v[bhr_pkg::PROM_IN_BIT] = prom_v;
        return v;
    endfunction : hw_exp

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    task automatic wr(input logic [1:0] dw, input logic [3:0] be_n, input logic [31:0] dv);
        logic [31:0] m;
        logic [15:0] hm;
        logic [15:0] hd;
        logic [3:0]  off;
        m = lmask(be_n);
        for (int k = 0; k < 2; k++)
        begin
            hm  = m[16*k +: 16];
            hd  = dv[16*k +: 16];
            off = {dw, k[0], 1'b0};
            for (int i = 0; i < bhr_pkg::N_RW; i++)
                if (bsel_m == bhr_pkg::RW_BANK[i] && off == bhr_pkg::RW_OFF[i])
                    rw_m[i] = (rw_m[i] & ~hm) | (hd & hm);
            if (bsel_m == bhr_pkg::ERR_BANK && off == bhr_pkg::ERR_OFF)
                err_m = err_m & ~(hd & hm);
            if (off == bhr_pkg::BSEL_OFF)
                bsel_m = (bsel_m & ~hm) | (hd & hm);
        end
        rw_m[bhr_pkg::R_PROM] &= bhr_pkg::PROM_RW_MASK;
        err_m = err_m | eset;
        host_u.op(1'b1, dw, be_n, dv);
    endtask : wr

    task automatic rdx(input logic [1:0] dw, input logic [3:0] be_n, input logic [31:0] e);
        exp_q.push_back(e & lmask(be_n));
        err_m = err_m | eset;
        host_u.op(1'b0, dw, be_n, 32'h0000_0000);
    endtask : rdx

    task automatic rd(input logic [1:0] dw, input logic [3:0] be_n);
        rdx(dw, be_n, {hw_exp({dw, 2'h2}), hw_exp({dw, 2'h0})});
    endtask : rd

    task automatic chk_outs();
        check("bank_selector", bank_selector, bsel_m);
        check("io_base_address", io_base_address, rw_m[bhr_pkg::R_BASE]);
        check("station_address", station_address, {rw_m[5], rw_m[4], rw_m[3]});
        check("rx_flow_watermark", rx_flow_watermark, rw_m[bhr_pkg::R_WMARK]);
        check("host_burst_length", host_burst_length, rw_m[bhr_pkg::R_BURST]);
        check("internal_bus_control", internal_bus_control, rw_m[bhr_pkg::R_IBC]);
        check("host_bus_cfg", host_bus_configuration, rw_m[bhr_pkg::R_BCFG]);
        check("serial_prom_control", serial_prom_control, rw_m[bhr_pkg::R_PROM][3:0]);
        check("global_soft_reset", global_soft_reset, rw_m[bhr_pkg::R_GRST][0]);
    endtask : chk_outs

    // read results are compared in arrival order
    always @(negedge clock)
        if (io_data_oe === 1'b1)
        begin
            if (exp_q.size() == 0) check("unexpected read data", 64'h1, 64'h0);
            else check("io_data_out", io_data_out, exp_q.pop_front());
        end

    initial
    begin
        #(50 * 20000);
        n_fail++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        seed = 32'h8f1d5f3a;
        eset = 16'h0000;
        bist_v = 16'h0000;
        prom_v = 1'b1;
        core_pkt_we = 1'b0;
        core_pkt_addr = 4'h0;
        core_pkt_wdata = 32'h0000_0000;
        bsel_m = 16'h0000;
        err_m = 16'h0000;
        for (int i = 0; i < bhr_pkg::N_RW; i++) rw_m[i] = 16'h0000;
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        r = rnd();
        bist_v = r[15:0];
        chk_outs();
        // every location of banks 0 to 8 read whole after reset
        for (int b = 0; b < 9; b++)
        begin
            wr(2'h3, 4'h3, {b[15:0], 16'h0000});
            for (int w = 0; w < 4; w++) rd(w[1:0], 4'h0);
        end
        host_u.idle();
        $display("done: reset map");
        // random banks, lanes and data, back to back with status inputs moving
        for (int it = 0; it < 200; it++)
        begin
            r = rnd();
            bist_v = r[15:0];
            prom_v = r[16];
            d = rnd();
            eset = (r[19:18] == 2'h0) ? d[15:0] : 16'h0000;
            wr(2'h3, bs_tab[r[21:20] % 3], {13'h0000, r[24:22], r[15:0]});
            eset = 16'h0000;
            r = rnd();
            d = rnd();
            if (r[1:0] == 2'h3) d[31:19] = 13'h0000;
            wr(r[1:0], be_tab[r[4:2] % 7], d);
            rd(r[6:5], be_tab[r[9:7] % 7]);
            if (r[10]) host_u.idle();
            chk_outs();
        end
        host_u.idle();
        $display("done: random access");
        // packet store: core fills, host reads across the pointer wrap, host writes back
        wr(2'h3, 4'h3, {bhr_pkg::PKT_BANK, 16'h0000});
        host_u.idle();
        for (int k = 0; k < 16; k++)
        begin
            pk[k] = rnd();
            core_pkt_we = 1'b1;
            core_pkt_addr = k[3:0];
            core_pkt_wdata = pk[k];
            @(negedge clock);
        end
        core_pkt_we = 1'b0;
        wr(2'h1, 4'hE, 32'h0000_000E);
        rdx(2'h2, 4'h0, pk[14]);
        rdx(2'h2, 4'h0, pk[15]);
        rdx(2'h2, 4'h0, pk[0]);
        rdx(2'h1, 4'hC, 32'h0000_0001);
        wr(2'h1, 4'hE, 32'h0000_0005);
        wr(2'h2, 4'h0, pk[1]);
        wr(2'h2, 4'h0, pk[2]);
        host_u.idle();
        core_pkt_addr = 4'h5;
        @(negedge clock);
        check("core_pkt_rdata", core_pkt_rdata, pk[1]);
        core_pkt_addr = 4'h6;
        @(negedge clock);
        check("core_pkt_rdata", core_pkt_rdata, pk[2]);
        check("pending reads", exp_q.size(), 0);
        $display("done: packet path");
        test_done();
    end
endmodule : tb_bhr_io_window
`default_nettype wire
